/* design/aos_pkg.sv */
// shared constants and types for the acceleration output and init sequencer
package aos_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    // filtered sample period and pulse-code bit rate
    localparam int unsigned SAMPLE_PERIOD_NS = 16000;
    localparam int unsigned SAMPLE_CYCLES = (SAMPLE_PERIOD_NS * 125) / 1000;
    localparam int unsigned SUB_STEPS = 16;
    localparam int unsigned SUB_CYCLES = SAMPLE_CYCLES / SUB_STEPS;
    localparam int unsigned PCM_HZ = 4000000;
    localparam int unsigned PCM_CYCLES = CLK_HZ / PCM_HZ;
    // start-up delays, microseconds
    localparam int unsigned LINK_READY_DELAY_US = 1000;
    localparam int unsigned FILTER_READY_DELAY_US = 50000;
    localparam int unsigned LINK_READY_CYCLES = LINK_READY_DELAY_US * (CLK_HZ / 1000000);
    localparam int unsigned FILTER_READY_CYCLES = FILTER_READY_DELAY_US * (CLK_HZ / 1000000);
    // result word layout
    localparam int unsigned RES_W = 26;
    localparam int unsigned W10_MSB = 21;
    localparam int unsigned W10_LSB = 12;
    localparam int unsigned W8_LSB = 14;
    localparam int unsigned PCM_LSB = 13;
    localparam logic signed [25:0] CLIP_HI = 26'sh01fffff;
    localparam logic signed [25:0] CLIP_LO = -26'sh0200000;
    // register map
    localparam logic [3:0] ADDR_DATA = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_CFG2 = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
    localparam logic [3:0] ADDR_COMP = 4'h5;
    localparam logic [7:0] CFG2_RESET = 8'h00;
    localparam int unsigned CFG2_PCM_BIT = 0;
    localparam int unsigned CFG2_W8_BIT = 1;

    typedef enum logic [2:0] {
        SEQ_RESET = 3'b000,
        SEQ_FUSE = 3'b001,
        SEQ_LINK_WAIT = 3'b010,
        SEQ_FILT_WAIT = 3'b011,
        SEQ_RUN = 3'b100
    } aos_seq_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } aos_bus_req_t;
endpackage

/* design/aos_top.sv */
// acceleration output path (compensation, interpolation, scaling, pulse code) and start-up sequencer
// Notes on behaviour
// - correct offset, gain, non-linearity first
// - sixteen-step linear interpolation between samples
// - each sample delayed one sample period
// - answer from the two samples before the newest, weighted
// - timing error within one sixteenth period
// - clip 26-bit result, make 10/8 bits
// - bits 21..12 or 21..14, truncated
// - pulse-code pin only when enabled
// - 4 MHz density from upper 9 bits
// - start-up after power, under-voltage, clear
// - power-up: known state, no response
// - clear: init flag set, self-test clear
// - copy fuses to mirror, no response
// - link ready: short zero, long invalid
// - filter ready: flag cleared, data valid
// - overrange stays deterministic, saturating arithmetic
// - new sample every sixteen interpolation sub-steps
`timescale 1ns/1ps
module aos_top #(
    parameter int unsigned LINK_READY_CYC = aos_pkg::LINK_READY_CYCLES,
    parameter int unsigned FILTER_READY_CYC = aos_pkg::FILTER_READY_CYCLES,
    parameter int unsigned FUSE_WORDS = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // start-up causes
    input wire logic uv_reset,
    input wire logic clear_cmd,
    // filtered sample stream
    input wire logic [25:0] filt_data,
    input wire logic filt_valid,
    // fuse array
    output logic [2:0] fuse_addr,
    input wire logic [15:0] fuse_rdata,
    // data request from link layer
    input wire logic accel_req,
    input wire logic accel_req_long,
    output logic [9:0] accel_word,
    output logic accel_word_valid,
    output logic accel_data_ok,
    output logic link_ready,
    output logic init_flag,
    output logic self_test_active_flag,
    // test pulse-code pin
    output logic pcm_out,
    output logic pcm_oe_b,
    // register port
    input wire aos_pkg::aos_bus_req_t bus,
    output logic [31:0] rdata,
    output logic irq
);
    aos_pkg::aos_seq_t seq_q;
    logic [31:0] dly_q;
    logic [15:0] mirror_q [FUSE_WORDS];
    logic [2:0] fidx_q;
    logic [2:0] fuse_addr_dly_q;
    logic [1:0] fuse_vld_q;
    logic [7:0] cfg2_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic signed [25:0] comp_q;
    logic comp_vld_q;
    logic signed [25:0] s_new_q;
    logic signed [25:0] s_old_q;
    logic signed [25:0] s_hold_q;
    logic [3:0] phase_q;
    logic [6:0] sub_cnt_q;
    logic [4:0] pcm_div_q;
    logic [9:0] pcm_acc_q;
    logic signed [25:0] interp_q;
    logic signed [31:0] interp_d;
    logic signed [25:0] clip_d;
    logic [9:0] word_d;
    logic restart;
    logic stat_rd;
    logic [2:0] ev;

    assign restart = uv_reset | clear_cmd;

    always_ff @(posedge mclk) begin
        if (!rst_b || restart) begin
            seq_q <= aos_pkg::SEQ_RESET;
            dly_q <= 32'h0;
            fidx_q <= 3'h0;
        end else begin
            case (seq_q)
                aos_pkg::SEQ_RESET: begin
                    seq_q <= aos_pkg::SEQ_FUSE;
                end
                aos_pkg::SEQ_FUSE: begin
                    fidx_q <= fidx_q + 3'h1;
                    if (32'(fidx_q) == FUSE_WORDS - 1) begin
                        seq_q <= aos_pkg::SEQ_LINK_WAIT;
                    end
                end
                aos_pkg::SEQ_LINK_WAIT: begin
                    dly_q <= dly_q + 32'h1;
                    if (dly_q == LINK_READY_CYC - 1) begin
                        seq_q <= aos_pkg::SEQ_FILT_WAIT;
                        dly_q <= 32'h0;
                    end
                end
                aos_pkg::SEQ_FILT_WAIT: begin
                    dly_q <= dly_q + 32'h1;
                    if (dly_q == FILTER_READY_CYC - 1) begin
                        seq_q <= aos_pkg::SEQ_RUN;
                    end
                end
                aos_pkg::SEQ_RUN: begin
                    seq_q <= aos_pkg::SEQ_RUN;
                end
                default: begin
                    seq_q <= aos_pkg::SEQ_RESET;
                end
            endcase
        end
    end

    // fuse word arrives one cycle after its address
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            fuse_vld_q <= 2'b00;
        end else begin
            fuse_vld_q <= {fuse_vld_q[0], seq_q == aos_pkg::SEQ_FUSE};
        end
    end

    always_ff @(posedge mclk) begin
        fuse_addr <= fidx_q;
        fuse_addr_dly_q <= fuse_addr;
        if (fuse_vld_q[1]) begin
            mirror_q[fuse_addr_dly_q] <= fuse_rdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b || restart) begin
            link_ready <= 1'b0;
            init_flag <= 1'b1;
            self_test_active_flag <= 1'b0;
            accel_data_ok <= 1'b0;
        end else begin
            link_ready <= seq_q == aos_pkg::SEQ_FILT_WAIT || seq_q == aos_pkg::SEQ_RUN;
            init_flag <= seq_q != aos_pkg::SEQ_RUN;
            self_test_active_flag <= 1'b0;
            accel_data_ok <= seq_q == aos_pkg::SEQ_RUN;
        end
    end

    // offset, gain and square-law trim from mirror
    always_ff @(posedge mclk) begin
        logic signed [47:0] lin;
        logic signed [47:0] sq;
        logic signed [47:0] sum;
        lin = 48'sh0;
        sq = 48'sh0;
        sum = 48'sh0;
        if (!rst_b) begin
            comp_q <= 26'sh0;
            comp_vld_q <= 1'b0;
        end else begin
            comp_vld_q <= filt_valid;
            if (filt_valid) begin
                lin = (48'(signed'(filt_data)) * 48'(signed'(mirror_q[1]))) >>> 14;
                sq = ((48'(signed'(filt_data)) >>> 12) * (48'(signed'(filt_data)) >>> 12)) >>> 14;
                sq = (sq * 48'(signed'(mirror_q[2]))) >>> 14;
                sum = lin + sq + 48'(signed'(mirror_q[0]));
                if (sum > 48'(aos_pkg::CLIP_HI) * 2) begin
                    comp_q <= 26'sh1ffffff;
                end else if (sum < 48'(aos_pkg::CLIP_LO) * 2) begin
                    comp_q <= -26'sh1ffffff;
                end else begin
                    comp_q <= sum[25:0];
                end
            end
        end
    end

    // one sample per sixteen interpolation sub-steps
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s_hold_q <= 26'sh0;
            s_new_q <= 26'sh0;
            s_old_q <= 26'sh0;
        end else if (comp_vld_q) begin
            s_hold_q <= comp_q;
            s_new_q <= s_hold_q;
            s_old_q <= s_new_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b || comp_vld_q) begin
            phase_q <= 4'h0;
            sub_cnt_q <= 7'h0;
        end else if (32'(sub_cnt_q) == aos_pkg::SUB_CYCLES - 1) begin
            sub_cnt_q <= 7'h0;
            if (phase_q != 4'hf) begin
                phase_q <= phase_q + 4'h1;
            end
        end else begin
            sub_cnt_q <= sub_cnt_q + 7'h1;
        end
    end

    always_comb begin
        interp_d = 32'(s_old_q) + ((32'(s_new_q) - 32'(s_old_q)) * signed'(32'(phase_q))) / 32'sd16;
    end

    always_comb begin
        if (interp_q > aos_pkg::CLIP_HI) begin
            clip_d = aos_pkg::CLIP_HI;
        end else if (interp_q < aos_pkg::CLIP_LO) begin
            clip_d = aos_pkg::CLIP_LO;
        end else begin
            clip_d = interp_q;
        end
        if (cfg2_q[aos_pkg::CFG2_W8_BIT]) begin
            word_d = {2'b00, clip_d[aos_pkg::W10_MSB:aos_pkg::W8_LSB]};
        end else begin
            word_d = clip_d[aos_pkg::W10_MSB:aos_pkg::W10_LSB];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            interp_q <= 26'sh0;
        end else begin
            interp_q <= interp_d[25:0];
        end
    end

    // short read zero before data valid
    always_ff @(posedge mclk) begin
        if (!rst_b || restart) begin
            accel_word <= 10'h0;
            accel_word_valid <= 1'b0;
        end else begin
            accel_word_valid <= accel_req && link_ready;
            if (accel_req && link_ready) begin
                if (accel_data_ok || accel_req_long) begin
                    accel_word <= word_d;
                end else begin
                    accel_word <= 10'h0;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        logic [9:0] sum9;
        sum9 = 10'h0;
        if (!rst_b || !cfg2_q[aos_pkg::CFG2_PCM_BIT]) begin
            pcm_div_q <= 5'h0;
            pcm_acc_q <= 10'h0;
            pcm_out <= 1'b0;
            pcm_oe_b <= 1'b1;
        end else begin
            pcm_oe_b <= 1'b0;
            if (32'(pcm_div_q) == aos_pkg::PCM_CYCLES - 1) begin
                pcm_div_q <= 5'h0;
                sum9 = {1'b0, pcm_acc_q[8:0]}
                    + {1'b0, ~clip_d[aos_pkg::W10_MSB], clip_d[20:aos_pkg::PCM_LSB]};
                pcm_acc_q <= sum9;
                pcm_out <= sum9[9];
            end else begin
                pcm_div_q <= pcm_div_q + 5'h1;
            end
        end
    end

    // events: link ready, data valid, restart
    assign ev = {restart, (seq_q == aos_pkg::SEQ_FILT_WAIT) && (dly_q == FILTER_READY_CYC - 1),
        (seq_q == aos_pkg::SEQ_LINK_WAIT) && (dly_q == LINK_READY_CYC - 1)};
    assign stat_rd = bus.rd && bus.addr == aos_pkg::ADDR_IRQ_STAT;

    // set wins over read-clear
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_stat_q <= 3'h0;
        end else begin
            irq_stat_q <= (stat_rd ? 3'h0 : irq_stat_q) | ev;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((stat_rd ? 3'h0 : irq_stat_q) | ev) & irq_mask_q);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cfg2_q <= aos_pkg::CFG2_RESET;
            irq_mask_q <= 3'h0;
        end else if (bus.wr) begin
            if (bus.addr == aos_pkg::ADDR_CFG2) begin
                cfg2_q <= bus.wdata[7:0];
            end
            if (bus.addr == aos_pkg::ADDR_IRQ_MASK) begin
                irq_mask_q <= bus.wdata[2:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rdata <= 32'h0;
        end else if (bus.rd) begin
            case (bus.addr)
                aos_pkg::ADDR_DATA: rdata <= {22'h0, word_d};
                aos_pkg::ADDR_STATUS: rdata <= {26'h0, seq_q, accel_data_ok,
                    self_test_active_flag, init_flag};
                aos_pkg::ADDR_CFG2: rdata <= {24'h0, cfg2_q};
                aos_pkg::ADDR_IRQ_STAT: rdata <= {29'h0, irq_stat_q};
                aos_pkg::ADDR_IRQ_MASK: rdata <= {29'h0, irq_mask_q};
                aos_pkg::ADDR_COMP: rdata <= {6'h0, comp_q};
                default: rdata <= 32'h0;
            endcase
        end else begin
            rdata <= 32'h0;
        end
    end
endmodule // aos_top

/* dv/aos_assertions.sv */
// port assertions for the acceleration output and start-up sequencer
`timescale 1ns/1ps
module aos_assertions #(
    parameter int unsigned LINK_READY_CYC = 20,
    parameter int unsigned FILTER_READY_CYC = 50,
    parameter int unsigned FUSE_WORDS = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // causes and requests
    input wire logic uv_reset,
    input wire logic clear_cmd,
    input wire logic accel_req,
    input wire logic accel_req_long,
    // observed outputs
    input wire logic [9:0] accel_word,
    input wire logic accel_word_valid,
    input wire logic accel_data_ok,
    input wire logic link_ready,
    input wire logic init_flag,
    input wire logic self_test_active_flag,
    input wire logic pcm_out,
    input wire logic pcm_oe_b
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_boot;
        $rose(rst_b) |-> init_flag && !link_ready && !accel_data_ok;
    endproperty
    a_boot: assert property (p_boot) else $error("bad state after reset");
    property p_fuse;
        $rose(rst_b) |-> !link_ready [*8];
    endproperty
    a_fuse: assert property (p_fuse) else $error("link ready during fuse copy");
    property p_restart;
        (clear_cmd || uv_reset) |=> init_flag && !link_ready && !accel_data_ok;
    endproperty
    a_restart: assert property (p_restart) else $error("restart not taken");
    property p_resp;
        accel_req && link_ready |=> accel_word_valid;
    endproperty
    a_resp: assert property (p_resp) else $error("request not answered");
    property p_noresp;
        accel_word_valid |-> $past(accel_req && link_ready);
    endproperty
    a_noresp: assert property (p_noresp) else $error("answer without request");
    property p_short0;
        accel_req && link_ready && !accel_req_long && !accel_data_ok |=> accel_word == 10'h000;
    endproperty
    a_short0: assert property (p_short0) else $error("early short read not zero");
    property p_st;
        !self_test_active_flag;
    endproperty
    a_st: assert property (p_st) else $error("self-test flag set");
    property p_pcm;
        pcm_oe_b |-> !pcm_out;
    endproperty
    a_pcm: assert property (p_pcm) else $error("pulse pin active while released");
    property p_ready;
        $fell(init_flag) |-> link_ready && accel_data_ok;
    endproperty
    a_ready: assert property (p_ready) else $error("init flag cleared too soon");
    property p_link;
        $rose(link_ready) |-> init_flag;
    endproperty
    a_link: assert property (p_link) else $error("link ready without init flag");
endmodule // aos_assertions

bind aos_top aos_assertions #(
    .LINK_READY_CYC(LINK_READY_CYC),
    .FILTER_READY_CYC(FILTER_READY_CYC),
    .FUSE_WORDS(FUSE_WORDS)
) aos_assertions_i (.mclk(mclk), .rst_b(rst_b), .uv_reset(uv_reset), .clear_cmd(clear_cmd),
    .accel_req(accel_req), .accel_req_long(accel_req_long), .accel_word(accel_word),
    .accel_word_valid(accel_word_valid), .accel_data_ok(accel_data_ok),
    .link_ready(link_ready), .init_flag(init_flag),
    .self_test_active_flag(self_test_active_flag), .pcm_out(pcm_out), .pcm_oe_b(pcm_oe_b));

/* dv/aos_link_master.sv */
// polling link master issuing acceleration data requests
`timescale 1ns/1ps
module aos_link_master (
    // clock
    input wire logic mclk,
    // command from bench
    input wire logic go,
    input wire logic long_in,
    input wire logic [3:0] gap,
    // request to device
    output logic accel_req = 1'b0,
    output logic accel_req_long = 1'b0
);
    logic [3:0] cnt_q = 4'h0;
    logic pend_q = 1'b0;
    logic long_q = 1'b0;
    // waits gap cycles, then one request pulse
    always_ff @(posedge mclk) begin
        accel_req <= 1'b0;
        if (go) begin
            cnt_q <= gap;
            pend_q <= 1'b1;
            long_q <= long_in;
        end else if (pend_q && cnt_q == 4'h0) begin
            accel_req <= 1'b1;
            accel_req_long <= long_q;
            pend_q <= 1'b0;
        end else if (pend_q) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule // aos_link_master

/* dv/aos_top_bench.sv */
// self-checking bench for the acceleration output and start-up sequencer
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module aos_top_bench;
    logic mclk = 1'b0, rst_b = 1'b0, uv_reset = 1'b0, clear_cmd = 1'b0, filt_valid = 1'b0;
    logic go = 1'b0, long_in = 1'b0, accel_req, accel_req_long, rd_seen = 1'b0;
    logic [3:0] gap = 4'h0;
    logic [25:0] filt_data = 26'h0, sval = 26'h0123456;
    logic [25:0] vals [4] = '{26'h0123456, 26'h0400000, 26'h3c00000, 26'h0};
    logic [2:0] fuse_addr;
    logic [15:0] fuse_rdata = 16'h0000;
    logic [9:0] accel_word;
    logic accel_word_valid, accel_data_ok, link_ready, init_flag, st_flag, pcm_out, pcm_oe_b, irq;
    aos_pkg::aos_bus_req_t bus = '0;
    logic [31:0] rdata;
    logic [9:0] wq [$];
    logic [63:0] rq [$];
    logic [9:0] wexp;
    logic [63:0] rexp;
    int bad_count = 0, tests_run = 0, cyc = 0;
    always #4 mclk = ~mclk;
    aos_top #(.LINK_READY_CYC(20), .FILTER_READY_CYC(50), .FUSE_WORDS(8)) aos_top_i (
        .mclk(mclk), .rst_b(rst_b), .uv_reset(uv_reset), .clear_cmd(clear_cmd),
        .filt_data(filt_data), .filt_valid(filt_valid), .fuse_addr(fuse_addr),
        .fuse_rdata(fuse_rdata), .accel_req(accel_req), .accel_req_long(accel_req_long),
        .accel_word(accel_word), .accel_word_valid(accel_word_valid),
        .accel_data_ok(accel_data_ok), .link_ready(link_ready), .init_flag(init_flag),
        .self_test_active_flag(st_flag), .pcm_out(pcm_out), .pcm_oe_b(pcm_oe_b),
        .bus(bus), .rdata(rdata), .irq(irq));
    aos_link_master aos_link_master_i (.mclk(mclk), .go(go), .long_in(long_in), .gap(gap),
        .accel_req(accel_req), .accel_req_long(accel_req_long));
    // unity gain, no offset, no square term; sample every 2000 cycles
    always @(posedge mclk) begin
        fuse_rdata <= (fuse_addr == 3'd1) ? 16'h4000 : 16'h0000;
        filt_valid <= (cyc % 2000 == 0);
        filt_data <= sval;
        cyc <= cyc + 1;
        rd_seen <= bus.rd;
        if (accel_word_valid) begin
            wexp = wq.pop_front();
            `CHK("accel_word", wexp, accel_word)
        end
        if (rd_seen) begin
            rexp = rq.pop_front();
            `CHK("rdata", rexp[31:0], rdata & rexp[63:32])
        end
        if (cyc == 40000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic bw(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk) bus <= '0;
    endtask
    task automatic br(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        rq.push_back({m, e});
        @(posedge mclk) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk) bus <= '0;
    endtask
    task automatic poll(input logic lng, input logic [9:0] e);
        wq.push_back(e);
        @(posedge mclk) begin
            go <= 1'b1;
            long_in <= lng;
            gap <= 4'($urandom_range(0, 7));
        end
        @(posedge mclk) go <= 1'b0;
        repeat (12) @(posedge mclk);
    endtask
    function automatic logic [9:0] exp_word(input logic signed [25:0] v, input logic w8);
        logic signed [25:0] c;
        c = (v > aos_pkg::CLIP_HI) ? aos_pkg::CLIP_HI : (v < aos_pkg::CLIP_LO) ? aos_pkg::CLIP_LO : v;
        return w8 ? {2'b00, c[21:14]} : c[21:12];
    endfunction
    initial begin
        void'($urandom(28));
        vals[3] = 26'($urandom_range(0, 32'h3fffff)) - 26'h0200000;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        br(aos_pkg::ADDR_STATUS, 32'h1, 32'h3);
        repeat (30) @(posedge mclk);
        `CHK("link_ready", 1'b1, link_ready)
        poll(1'b0, 10'h000);
        repeat (60) @(posedge mclk);
        br(aos_pkg::ADDR_STATUS, 32'h24, 32'h3f);
        foreach (vals[i]) begin
            sval <= vals[i];
            repeat (6100) @(posedge mclk);
            for (int w = 0; w < 2; w++) begin
                bw(aos_pkg::ADDR_CFG2, 32'(w) << aos_pkg::CFG2_W8_BIT);
                poll(1'b0, exp_word(vals[i], w[0]));
                poll(1'b1, exp_word(vals[i], w[0]));
            end
        end
        bw(aos_pkg::ADDR_CFG2, 32'h1);
        repeat (40) @(posedge mclk);
        `CHK("pcm_oe_b", 1'b0, pcm_oe_b)
        bw(aos_pkg::ADDR_CFG2, 32'h0);
        repeat (3) @(posedge mclk);
        `CHK("pcm_oe_b", 1'b1, pcm_oe_b)
        `CHK("pcm_out", 1'b0, pcm_out)
        bw(aos_pkg::ADDR_IRQ_MASK, 32'h0);
        br(aos_pkg::ADDR_IRQ_STAT, 32'h3, 32'h7);
        @(posedge mclk) clear_cmd <= 1'b1;
        @(posedge mclk) clear_cmd <= 1'b0;
        bw(aos_pkg::ADDR_IRQ_MASK, 32'h4);
        repeat (2) @(posedge mclk);
        `CHK("irq", 1'b1, irq)
        br(aos_pkg::ADDR_IRQ_STAT, 32'h4, 32'h4);
        repeat (2) @(posedge mclk);
        `CHK("irq", 1'b0, irq)
        repeat (100) @(posedge mclk);
        `CHK("init_flag", 1'b0, init_flag)
        `CHK("st_flag", 1'b0, st_flag)
        br(4'hf, 32'h0, 32'hffffffff);
        @(posedge mclk) uv_reset <= 1'b1;
        @(posedge mclk) uv_reset <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK("link_ready", 1'b0, link_ready)
        repeat (10) @(posedge mclk);
        `CHK("pending", 0, wq.size() + rq.size())
        close_out();
    end
endmodule // aos_top_bench
